// File: rtl/fps_flash_program_security_ctrl.sv
`timescale 1ns/1ps
// Function
// - Top byte 50h secures; 00h/FFh do not
// - Secure: external code reads return no data
// - Secure: foreign code writes only full-erase code
// - Full erase completion clears protection
// - Secure: parallel program/verify refused, erase allowed
// - Protection latched only at reset
// - Select-line codes pick erase/program/verify/signature
// - Read data driven only while enable low
// - Port mapping of data and address bits
// - Identification bytes at 30h and 31h
// - Boot strap sets both boot selects
// - Boot serial uses receive and transmit pins
// - Baud measured from first colon
// - Programming starts only on valid first record
// - Secure serial session starts with full erase
// - Pause host during erase or write
// - Failed session halts until reset
// - Byte write call with code 5h, readback
// - High-voltage flag set during operation
module fps_flash_program_security_ctrl
  import fps_pkg::*;
#(
  parameter int          P_WRITE_CYC = WRITE_CYC,
  parameter int          P_ERASE_CYC = ERASE_CYC,
  parameter logic [7:0]  P_ID0       = ID0_DEFAULT,
  parameter logic [7:0]  P_ID1       = ID1_DEFAULT
)(
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  input  wire logic           i_ce,
  input  wire logic [7:0]     i_sec_byte,
  input  wire logic           i_rst_pin,
  input  wire logic           i_pss_n,
  input  wire logic           i_ea_n,
  input  wire logic [3:0]     i_sel,
  input  wire logic           i_we_n,
  input  wire logic [7:0]     i_p0_in,
  input  wire logic [7:0]     i_p1,
  input  wire logic [5:0]     i_p2_lo,
  input  wire logic           i_p3_4,
  output logic [7:0]          o_p0_out,
  output logic                o_p0_oe,
  input  wire logic [7:0]     i_flash_rdata,
  input  wire logic           i_code_rd_ext,
  output logic [7:0]          o_code_rdata,
  input  wire logic           i_fc_wr,
  input  wire logic [3:0]     i_fc_wdata,
  input  wire logic           i_fc_src_int,
  output logic [3:0]          o_flash_function_code,
  input  wire logic           i_call,
  input  wire logic [15:0]    i_call_addr,
  input  wire logic [15:0]    i_pointer_register,
  input  wire logic [7:0]     i_call_acc,
  output fps_flash_cmd_s      o_flash_cmd,
  output logic                o_flash_go,
  output logic                o_high_voltage_flag,
  output logic                o_op_done,
  output logic [7:0]          o_readback,
  output logic                o_sec_active,
  output logic                o_boot_select_hi,
  output logic                o_boot_select_lo,
  output logic                o_boot_mode,
  input  wire logic           i_rxd,
  input  wire logic           i_tx_bit,
  output logic                o_txd,
  output logic [BW-1:0]       o_baud_div,
  output logic                o_baud_valid,
  input  wire logic           i_rec_valid,
  input  wire logic [7:0]     i_record_kind_field,
  output logic                o_prog_allowed,
  output logic                o_full_erase_first,
  output logic                o_xoff,
  input  wire logic           i_session_fail,
  output logic                o_halted
);

  function automatic fps_op_e fps_call_op(input logic [3:0] fc, input logic [15:0] addr);
    fps_op_e op;
    op = OP_NONE;
    if (fc == FC_BYTE && addr == CALL_BYTE) op = OP_WRITE;
    if (fc == FC_PAGE && addr == CALL_PAGE) op = OP_PAGE;
    if (fc == FC_BLOCK && addr == CALL_BLOCK) op = OP_BLOCK;
    if (fc == FC_FULL && addr == CALL_FULL) op = OP_FULL;
    return op;
  endfunction

  logic           rst_s1;
  logic           rst_n_s;
  logic           captured;
  logic           we_q;
  logic           rx_q;
  logic           baud_run;
  logic           rec_seen;
  logic [BW-1:0]  baud_cnt;
  logic [TW-1:0]  cnt;
  fps_state_e     st;

  // Two-stage release of the reset
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      rst_s1  <= 1'b0;
      rst_n_s <= 1'b0;
    end
    else
    begin
      rst_s1  <= 1'b1;
      rst_n_s <= rst_s1;
    end

  wire cap_now    = i_ce && !captured;
  wire boot_strap = !i_pss_n && !i_ea_n;
  wire par_entry  = i_rst_pin && !i_pss_n && i_ea_n;
  wire [14:0] par_addr = {i_p3_4, i_p2_lo, i_p1};
  wire sel_erase  = par_entry && i_sel == SEL_ERASE;
  wire sel_prog   = par_entry && i_sel == SEL_PROG && !o_sec_active;
  wire sel_verify = par_entry && i_sel[2:0] == SEL_VERIFY && !o_sec_active;
  wire sel_sig    = par_entry && i_sel[2:0] == SEL_SIG;
  wire rd_en      = (sel_verify || sel_sig) && !i_sel[3];
  wire we_fall    = we_q && !i_we_n;
  wire fc_accept  = i_fc_wr && (!o_sec_active || i_fc_src_int || i_fc_wdata == FC_FULL);
  wire [7:0] sig_data = (par_addr == SIG_ADDR0) ? P_ID0 :
                        (par_addr == SIG_ADDR1) ? P_ID1 : 8'h00;
  wire [7:0] rd_data  = sel_sig ? sig_data : i_flash_rdata;
  wire fps_op_e par_op  = (we_fall && sel_erase) ? OP_FULL :
                          (we_fall && sel_prog) ? OP_WRITE : OP_NONE;
  wire fps_op_e call_op = i_call ? fps_call_op(o_flash_function_code, i_call_addr) : OP_NONE;
  wire fps_op_e start_op = (par_op != OP_NONE) ? par_op : call_op;
  wire start    = st == ST_IDLE && start_op != OP_NONE;
  wire [TW-1:0] start_cnt = (start_op == OP_WRITE) ? TW'(P_WRITE_CYC - 1) : TW'(P_ERASE_CYC - 1);
  wire [14:0] start_addr  = (par_op != OP_NONE) ? par_addr : i_pointer_register[14:0];
  wire [7:0]  start_data  = (par_op != OP_NONE) ? i_p0_in : i_call_acc;
  wire rx_fall  = o_boot_mode && rx_q && !i_rxd;
  wire rx_rise  = !rx_q && i_rxd;

  always_ff @(posedge i_clk or negedge rst_n_s)
    if (!rst_n_s)
    begin
      captured         <= 1'b0;
      o_sec_active     <= 1'b0;
      o_boot_select_hi <= 1'b0;
      o_boot_select_lo <= 1'b0;
      o_boot_mode      <= 1'b0;
    end
    else if (i_ce)
    begin
      if (cap_now)
      begin
        captured         <= 1'b1;
        o_sec_active     <= i_sec_byte == SEC_ON;
        o_boot_select_hi <= boot_strap;
        o_boot_select_lo <= boot_strap;
        o_boot_mode      <= boot_strap;
      end
      else if (st == ST_DONE && o_flash_cmd.op == OP_FULL)
        o_sec_active <= 1'b0;
    end

  // Operation sequencer; timing is internal, the pulse only starts it
  always_ff @(posedge i_clk or negedge rst_n_s)
    if (!rst_n_s)
    begin
      st                  <= ST_IDLE;
      cnt                 <= '0;
      o_flash_cmd         <= '0;
      o_flash_go          <= 1'b0;
      o_high_voltage_flag <= 1'b0;
      o_op_done           <= 1'b0;
      o_readback          <= 8'h00;
    end
    else if (i_ce)
    begin
      o_flash_go <= start;
      o_op_done  <= st == ST_DONE;
      case (st)
        ST_IDLE:
          if (start)
          begin
            st                  <= ST_BUSY;
            cnt                 <= start_cnt;
            o_flash_cmd         <= '{op: start_op, addr: start_addr, data: start_data};
            o_high_voltage_flag <= 1'b1;
          end
        ST_BUSY:
          if (cnt == '0)
          begin
            st                  <= ST_DONE;
            o_high_voltage_flag <= 1'b0;
          end
          else
            cnt <= cnt - 1'b1;
        ST_DONE:
        begin
          st         <= ST_IDLE;
          o_readback <= i_flash_rdata;
        end
        default:
          st <= ST_IDLE;
      endcase
    end

  always_ff @(posedge i_clk or negedge rst_n_s)
    if (!rst_n_s)
    begin
      we_q                  <= 1'b1;
      rx_q                  <= 1'b1;
      o_flash_function_code <= FC_RESET;
      o_code_rdata          <= 8'h00;
      o_p0_out              <= 8'h00;
      o_p0_oe               <= 1'b0;
    end
    else if (i_ce)
    begin
      we_q    <= i_we_n;
      rx_q    <= i_rxd;
      o_p0_oe <= rd_en;
      if (rd_en)
        o_p0_out <= rd_data;
      if (fc_accept)
        o_flash_function_code <= i_fc_wdata;
      o_code_rdata <= (o_sec_active && i_code_rd_ext) ? READ_BLOCKED : i_flash_rdata;
    end

  // Boot serial side: first low run of the colon spans start bit plus bit 0
  always_ff @(posedge i_clk or negedge rst_n_s)
    if (!rst_n_s)
    begin
      baud_run           <= 1'b0;
      baud_cnt           <= '0;
      o_baud_div         <= '0;
      o_baud_valid       <= 1'b0;
      o_txd              <= 1'b1;
      rec_seen           <= 1'b0;
      o_prog_allowed     <= 1'b0;
      o_full_erase_first <= 1'b0;
      o_xoff             <= 1'b0;
      o_halted           <= 1'b0;
    end
    else if (i_ce)
    begin
      o_txd <= o_boot_mode ? i_tx_bit : 1'b1;
      if (rx_fall && !o_baud_valid && !baud_run)
      begin
        baud_run <= 1'b1;
        baud_cnt <= {{(BW-1){1'b0}}, 1'b1};                                            // Edge cycle is low too
      end
      else if (baud_run && rx_rise)
      begin
        baud_run     <= 1'b0;
        o_baud_valid <= 1'b1;
        o_baud_div   <= {1'b0, baud_cnt[BW-1:1]};
      end
      else if (baud_run && baud_cnt != '1)
        baud_cnt <= baud_cnt + 1'b1;
      if (o_boot_mode && i_rec_valid && !rec_seen)
      begin
        rec_seen       <= 1'b1;
        o_prog_allowed <= i_record_kind_field == REC_DATA || i_record_kind_field == REC_END;
      end
      o_full_erase_first <= o_boot_mode && o_sec_active;
      o_xoff             <= o_boot_mode && (st == ST_BUSY);
      if (o_boot_mode && i_session_fail)
        o_halted <= 1'b1;
    end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_s);

  a_fc_locked: assert property (i_ce && captured && o_sec_active && i_fc_wr && !i_fc_src_int &&
    i_fc_wdata != FC_FULL |=> $stable(o_flash_function_code)) else $error("function code changed while locked");
  a_full_clears: assert property (i_ce && st == ST_DONE && o_flash_cmd.op == OP_FULL
    |=> !o_sec_active) else $error("protection kept after full erase");
  a_code_blocked: assert property (i_ce && o_sec_active && i_code_rd_ext
    |=> o_code_rdata == READ_BLOCKED) else $error("protected flash returned to external code");
  a_prog_refused: assert property (i_ce && o_sec_active && st == ST_IDLE && par_entry && i_sel == SEL_PROG
    && we_fall && !i_call |=> st == ST_IDLE && !o_flash_go) else $error("program accepted while protected");
  a_sec_latched: assert property ($rose(o_sec_active) |-> $past(!captured))
    else $error("protection rose outside reset capture");
  a_hv_busy: assert property (i_ce && st == ST_BUSY && cnt != '0 |=> o_high_voltage_flag && st == ST_BUSY)
    else $error("high voltage flag dropped during operation");
  a_drive_gate: assert property ($rose(o_p0_oe) |-> $past(par_entry && !i_sel[3]))
    else $error("data driven without enable");
  a_sig_byte: assert property (i_ce && rd_en && sel_sig && par_addr == SIG_ADDR1
    |=> o_p0_out == P_ID1 && o_p0_oe) else $error("wrong identification byte");
  a_boot_sel: assert property ($rose(o_boot_mode) |-> o_boot_select_hi && o_boot_select_lo)
    else $error("boot selects not set");
  a_halt_sticky: assert property (o_halted |=> o_halted)
    else $error("halt released without reset");

  c_full_erase: cover property (st == ST_DONE && o_flash_cmd.op == OP_FULL);
  c_write_done: cover property (st == ST_DONE && o_flash_cmd.op == OP_WRITE);
  c_sig_read: cover property (o_p0_oe && sel_sig);
  c_baud: cover property ($rose(o_baud_valid));
endmodule

// File: rtl/fps_pkg.sv
package fps_pkg;
  // Protection byte location and codes
  localparam logic [14:0] SEC_ADDR     = 15'h7fff;
  localparam logic [7:0]  SEC_ON       = 8'h50;
  localparam logic [7:0]  SEC_OFF0     = 8'h00;
  localparam logic [7:0]  SEC_OFF1     = 8'hff;
  localparam logic [7:0]  READ_BLOCKED = 8'hff;
  // Function codes
  localparam logic [3:0]  FC_RESET = 4'h0;
  localparam logic [3:0]  FC_BYTE  = 4'h5;
  localparam logic [3:0]  FC_PAGE  = 4'hc;
  localparam logic [3:0]  FC_BLOCK = 4'h3;
  localparam logic [3:0]  FC_FULL  = 4'ha;
  // Boot ROM routine entry addresses
  localparam logic [15:0] CALL_BYTE  = 16'hffad;
  localparam logic [15:0] CALL_PAGE  = 16'hffaa;
  localparam logic [15:0] CALL_BLOCK = 16'hffa5;
  localparam logic [15:0] CALL_FULL  = 16'hffa0;
  // Parallel select lines {p2.7, p2.6, p3.7, p3.6}
  localparam logic [3:0]  SEL_ERASE  = 4'hd;
  localparam logic [3:0]  SEL_PROG   = 4'hb;
  localparam logic [2:0]  SEL_VERIFY = 3'h3;
  localparam logic [2:0]  SEL_SIG    = 3'h0;
  localparam logic [14:0] SIG_ADDR0  = 15'h0030;
  localparam logic [14:0] SIG_ADDR1  = 15'h0031;
  // Identification bytes: values arbitrary
  localparam logic [7:0]  ID0_DEFAULT = 8'ha5;
  localparam logic [7:0]  ID1_DEFAULT = 8'h3c;
  // Record kinds
  localparam logic [7:0]  REC_DATA = 8'h00;
  localparam logic [7:0]  REC_END  = 8'h01;
  // Timing
  localparam int CLK_MHZ    = 100;
  localparam int T_WRITE_US = 2500;
  localparam int T_ERASE_US = 5000;
  localparam int WRITE_CYC  = T_WRITE_US * CLK_MHZ;
  localparam int ERASE_CYC  = T_ERASE_US * CLK_MHZ;
  localparam int TW         = 20;
  localparam int BW         = 16;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_WRITE = 3'b001,
    OP_PAGE  = 3'b010,
    OP_BLOCK = 3'b011,
    OP_FULL  = 3'b100
  } fps_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b10
  } fps_state_e;

  typedef struct packed {
    fps_op_e     op;
    logic [14:0] addr;
    logic [7:0]  data;
  } fps_flash_cmd_s;
endpackage

// File: sim/flash_program_security_ctrl_test.sv
`timescale 1ns/1ps
module flash_program_security_ctrl_test;
  import fps_pkg::*;
  localparam int WC = 20;
  localparam int EC = 40;
  logic i_clk, i_rst_n, i_ce, i_rst_pin, i_pss_n, i_ea_n, i_we_n, i_code_rd_ext, i_fc_wr, i_fc_src_int, i_call;
  logic i_rxd, i_tx_bit, i_rec_valid, i_session_fail, o_p0_oe, o_flash_go, o_high_voltage_flag, o_op_done;
  logic o_sec_active, o_boot_select_hi, o_boot_select_lo, o_boot_mode, o_txd, o_baud_valid, o_prog_allowed;
  logic o_full_erase_first, o_xoff, o_halted;
  logic [3:0] i_sel, i_fc_wdata, o_flash_function_code;
  logic [7:0] i_sec_byte, i_p0_in, o_p0_out, i_flash_rdata, o_code_rdata, i_call_acc, o_readback;
  logic [7:0] i_record_kind_field;
  logic [14:0] addr;
  logic [15:0] i_call_addr, i_pointer_register;
  logic [BW-1:0] o_baud_div;
  fps_flash_cmd_s o_flash_cmd;
  int num_errors, comparisons;

  fps_flash_program_security_ctrl #(.P_WRITE_CYC(WC), .P_ERASE_CYC(EC)) dut (
    .i_clk, .i_rst_n, .i_ce, .i_sec_byte, .i_rst_pin, .i_pss_n, .i_ea_n, .i_sel, .i_we_n, .i_p0_in,
    .i_p1(addr[7:0]), .i_p2_lo(addr[13:8]), .i_p3_4(addr[14]), .o_p0_out, .o_p0_oe, .i_flash_rdata,
    .i_code_rd_ext, .o_code_rdata, .i_fc_wr, .i_fc_wdata, .i_fc_src_int, .o_flash_function_code, .i_call,
    .i_call_addr, .i_pointer_register, .i_call_acc, .o_flash_cmd, .o_flash_go, .o_high_voltage_flag,
    .o_op_done, .o_readback, .o_sec_active, .o_boot_select_hi, .o_boot_select_lo, .o_boot_mode, .i_rxd,
    .i_tx_bit, .o_txd, .o_baud_div, .o_baud_valid, .i_rec_valid, .i_record_kind_field, .o_prog_allowed,
    .o_full_erase_first, .o_xoff, .i_session_fail, .o_halted);
  fps_programmer_model prog (.i_clk, .i_p0_out(o_p0_out), .i_p0_oe(o_p0_oe), .o_rst_pin(i_rst_pin),
    .o_pss_n(i_pss_n), .o_ea_n(i_ea_n), .o_sel(i_sel), .o_we_n(i_we_n), .o_p0_in(i_p0_in), .o_addr(addr));

  initial
  begin
    i_clk = 1'b0;
    // Fast clock; operation lengths come in as cycle parameters
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset(input logic [7:0] sec, input logic ea_n);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_sec_byte <= sec;
    prog.strap(ea_n);
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
  endtask

  task automatic par_op(input logic [3:0] sel, input logic [14:0] a, input logic go, input fps_op_e op);
    int t_go;
    int t_done;
    t_go = -1;
    t_done = -1;
    fork
      prog.pulse(sel, a, 8'h9a, 3);
      for (int n = 0; n < EC + 20; n++)
      begin
        @(posedge i_clk);
        #1;
        if (o_op_done === 1'b1)
          t_done = n;
        if (o_flash_go === 1'b1)
        begin
          t_go = n;
          check("hv", o_high_voltage_flag, 1);
          check("op", o_flash_cmd.op, op);
          if (op == OP_WRITE)
            check("cmd", o_flash_cmd, {op, a, 8'h9a});
        end
      end
    join
    check("go", t_go >= 0, go);
    if (go)
      check("busy", t_done - t_go, (op == OP_FULL ? EC : WC) + 1);
  endtask

  task automatic par_read(input logic [3:0] sel, input logic [14:0] a, input logic [7:0] d, input logic oe);
    logic [7:0] v;
    logic e;
    prog.read(sel, a, v, e);
    check("oe", e, oe);
    if (oe)
      check("rdata", v, d);
    repeat (2) @(posedge i_clk);
    #1;
    check("oe off", o_p0_oe, 0);
  endtask

  // Foreign code: code fetch together with byte code, then full-erase code
  task automatic sec_access(input logic sec);
    @(posedge i_clk);
    i_code_rd_ext <= 1'b1;
    i_fc_src_int <= 1'b0;
    i_fc_wr <= 1'b1;
    i_fc_wdata <= FC_BYTE;
    @(posedge i_clk);
    i_fc_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("code", o_code_rdata, sec ? READ_BLOCKED : i_flash_rdata);
    check("fc", o_flash_function_code, sec ? FC_RESET : FC_BYTE);
    @(posedge i_clk);
    i_code_rd_ext <= 1'b0;
    i_fc_wr <= 1'b1;
    i_fc_wdata <= FC_FULL;
    @(posedge i_clk);
    i_fc_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("fc full", o_flash_function_code, FC_FULL);
  endtask

  task automatic do_call(input logic [3:0] fc, input logic [15:0] target, input logic [15:0] ptr,
                         input fps_op_e op);
    @(posedge i_clk);
    i_fc_wr <= 1'b1;
    i_fc_wdata <= fc;
    i_fc_src_int <= 1'b1;
    i_pointer_register <= ptr;
    @(posedge i_clk);
    i_fc_wr <= 1'b0;
    i_call <= 1'b1;
    i_call_addr <= target;
    @(posedge i_clk);
    i_call <= 1'b0;
    #1;
    for (int n = 0; n < 6 && o_flash_go !== 1'b1; n++)
      @(posedge i_clk) #1;
    check("call go", o_flash_go, 1);
    check("call cmd", {o_flash_cmd.op, o_flash_cmd.addr}, {op, ptr[14:0]});
    for (int n = 0; n < EC + 6 && o_op_done !== 1'b1; n++)
      @(posedge i_clk) #1;
    check("readback", o_readback, i_flash_rdata);
  endtask

  // Low run of start bit plus bit 0 40 cycles long, then two records back to back
  task automatic boot_serial();
    @(posedge i_clk);
    i_rxd <= 1'b0;
    repeat (40) @(posedge i_clk);
    i_rxd <= 1'b1;
    i_record_kind_field <= 8'h07;
    i_rec_valid <= 1'b1;
    i_tx_bit <= 1'b0;
    @(posedge i_clk);
    i_record_kind_field <= REC_DATA;
    @(posedge i_clk);
    i_rec_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    check("baud", {o_baud_valid, o_baud_div}, {1'b1, 16'h0014});
    check("prog ok", o_prog_allowed, 0);
    check("txd", o_txd, 0);
    check("halted", o_halted, 0);
  endtask

  // Internal page erase in secure boot mode, frozen by the enable, then a failed session
  task automatic boot_busy();
    @(posedge i_clk);
    i_fc_wr <= 1'b1;
    i_fc_wdata <= FC_PAGE;
    i_fc_src_int <= 1'b1;
    @(posedge i_clk);
    i_fc_wr <= 1'b0;
    i_call <= 1'b1;
    i_call_addr <= CALL_PAGE;
    @(posedge i_clk);
    i_call <= 1'b0;
    @(posedge i_clk);
    #1;
    check("xoff", o_xoff, 1);
    @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (EC + 4) @(posedge i_clk);
    i_ce <= 1'b1;
    #1;
    check("frozen hv", o_high_voltage_flag, 1);
    repeat (EC + 2) @(posedge i_clk);
    #1;
    check("xoff idle", o_xoff, 0);
    @(posedge i_clk);
    i_session_fail <= 1'b1;
    @(posedge i_clk);
    i_session_fail <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("halted", o_halted, 1);
  endtask

  initial
  begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    num_errors = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_sec_byte = 8'h00;
    i_flash_rdata = 8'h6b;
    i_code_rd_ext = 1'b0;
    i_fc_wr = 1'b0;
    i_fc_wdata = 4'h0;
    i_fc_src_int = 1'b0;
    i_call = 1'b0;
    i_call_addr = 16'h0000;
    i_pointer_register = 16'h0000;
    i_call_acc = 8'h9a;
    i_rxd = 1'b1;
    i_tx_bit = 1'b1;
    i_rec_valid = 1'b0;
    i_record_kind_field = 8'h00;
    i_session_fail = 1'b0;
    do_reset(SEC_OFF1, 1'b1);
    check("sec", o_sec_active, 0);
    check("txd", o_txd, 1);
    par_op(SEL_PROG, 15'h4263, 1'b1, OP_WRITE);
    par_read({1'b0, SEL_VERIFY}, 15'h4263, i_flash_rdata, 1'b1);
    par_read({1'b0, SEL_SIG}, SIG_ADDR0, ID0_DEFAULT, 1'b1);
    par_read({1'b0, SEL_SIG}, SIG_ADDR1, ID1_DEFAULT, 1'b1);
    sec_access(1'b0);
    do_call(FC_BYTE, CALL_BYTE, 16'h1263, OP_WRITE);
    do_call(FC_PAGE, CALL_PAGE, 16'h1260, OP_PAGE);
    do_reset(SEC_ON, 1'b1);
    check("sec", o_sec_active, 1);
    i_sec_byte <= SEC_OFF0;
    sec_access(1'b1);
    par_op(SEL_PROG, 15'h4263, 1'b0, OP_WRITE);
    par_read({1'b0, SEL_VERIFY}, 15'h4263, 8'h00, 1'b0);
    check("sec", o_sec_active, 1);
    par_op(SEL_ERASE, 15'h0000, 1'b1, OP_FULL);
    check("sec", o_sec_active, 0);
    do_reset(SEC_ON, 1'b0);
    check("boot", {o_boot_select_hi, o_boot_select_lo}, 2'b11);
    check("full first", o_full_erase_first, 1);
    par_op(SEL_ERASE, 15'h0000, 1'b0, OP_FULL);
    boot_serial();
    boot_busy();
    stop_test();
  end
endmodule

// File: sim/fps_programmer_model.sv
`timescale 1ns/1ps
module fps_programmer_model (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_p0_out,
  input  wire logic        i_p0_oe,
  output logic             o_rst_pin,
  output logic             o_pss_n,
  output logic             o_ea_n,
  output logic [3:0]       o_sel,
  output logic             o_we_n,
  output logic [7:0]       o_p0_in,
  output logic [14:0]      o_addr
);
  initial
  begin
    o_rst_pin = 1'b1;
    o_pss_n = 1'b0;
    o_ea_n = 1'b1;
    o_sel = 4'hf;
    o_we_n = 1'b1;
    o_p0_in = 8'h00;
    o_addr = 15'h0000;
  end
  // Held steady through reset; ea low picks boot instead
  task automatic strap(input logic ea_n);
    o_ea_n <= ea_n;
  endtask
  task automatic pulse(input logic [3:0] sel, input logic [14:0] a, input logic [7:0] d, input int len);
    @(posedge i_clk);
    o_sel <= sel;
    o_addr <= a;
    o_p0_in <= d;
    repeat (3) @(posedge i_clk);
    o_we_n <= 1'b0;
    repeat (len) @(posedge i_clk);
    o_we_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_sel <= 4'hf;
    // Released bus shows junk, not the last byte
    o_p0_in <= ~d;
  endtask
  task automatic read(input logic [3:0] sel, input logic [14:0] a, output logic [7:0] d, output logic oe);
    @(posedge i_clk);
    o_sel <= sel;
    o_addr <= a;
    repeat (3) @(posedge i_clk);
    #1;
    d = i_p0_out;
    oe = i_p0_oe;
    @(posedge i_clk);
    o_sel <= 4'hf;
  endtask
endmodule
